// >>> rtl/fsf_pkg.sv
/*
 fsf_pkg: constants, register map and carrier types of the fifo status-flag and
 retransmit block.
 assumes one clock (clk, 100 MHz) for write side, read side and register port.
*/
// Overview of operation
// - standard mode: almost-empty when count <= n
// - fall-through mode: almost-empty when count <= n+1
// - async timing: assert on read, release on write
// - sync timing: almost-empty updated on read clock
// - half-full asserted by write passing half depth
// - half-full released by read reaching half depth
// - standard: half-full after depth/2+1 writes
// - fall-through: half-full after D/2+2 writes
// - output width 36, 18 or 9 at reset
// - full released one cycle after read
// - empty released one cycle after write
// - first word readable one cycle after write
// - retransmit mode sampled during master reset
// - zero latency retransmit: data and empty immediate
// - flag timing mode sampled during master reset
// - thresholds counted in selected width words
package fsf_pkg;

    localparam int FSF_DEPTH_DEF = 1024;
    localparam int FSF_DATA_W = 36;
    localparam int FSF_ADDR_W = 4;

    // register byte addresses
    localparam logic [3:0] FSF_REG_OFFSET = 4'h0;
    localparam logic [3:0] FSF_REG_STATUS = 4'h4;
    localparam logic [3:0] FSF_REG_COUNT = 4'h8;

    // empty offset after master reset
    localparam logic [31:0] FSF_EMPTY_OFFSET_RST = 32'h0000_0007;

    // status register field positions
    localparam int FSF_ST_EMPTY = 0;
    localparam int FSF_ST_FULL = 1;
    localparam int FSF_ST_AEMPTY = 2;
    localparam int FSF_ST_HFULL = 3;
    localparam int FSF_ST_FIRST_WORD_FALL_THROUGH = 4;
    localparam int FSF_ST_SYNCF = 5;
    localparam int FSF_ST_NORMRT = 6;
    localparam int FSF_ST_WIDTH = 8;

    // output width codes
    localparam logic [1:0] FSF_W36 = 2'h0;
    localparam logic [1:0] FSF_W18 = 2'h1;
    localparam logic [1:0] FSF_W9 = 2'h2;

    // flag release takes this many cycles after the freeing event
    localparam int FSF_FLAG_DELAY_CYC = 1;

    // configuration pins, bit order of the synchroniser vector
    typedef struct packed {
        logic [1:0] outputWidthSelect;
        logic firstWordFallThrough;
        logic flagTimingSelect;
        logic retransmitModeSelect;
        logic partialResetN;
        logic masterResetN;
    } fsf_pins_s;

    // settings captured while master reset is low
    typedef struct packed {
        logic [1:0] width;
        logic first_word_fall_through;
        logic syncFlags;
        logic normalRetx;
    } fsf_cfg_s;

endpackage : fsf_pkg

// >>> rtl/fsf_fifo_flags.sv
/*
 fsf_fifo_flags: fifo storage with empty, full, almost-empty and half-full flags,
 selectable output width, fall-through mode and two retransmit variants.
 assumes producer, consumer and register master on clk; reset and mode pins
 come from outside and are synchronised here.
*/
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module fsf_fifo_flags
    import fsf_pkg::*;
#(
    parameter int DEPTH = FSF_DEPTH_DEF
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins sampled through two flops
    input wire fsf_pins_s pins,
    // write side
    input wire logic writeEn,
    input wire logic [FSF_DATA_W-1:0] writeData,
    // read side
    input wire logic readEn,
    input wire logic retransmitReq,
    output logic [FSF_DATA_W-1:0] readDataOut,
    // flags, active low
    output logic emptyFlagN,
    output logic fullFlagN,
    output logic inputReadyN,
    output logic almostEmptyFlagN,
    output logic halfFullFlagN,
    // register port
    input wire logic [FSF_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output logic [31:0] regRdData
);

    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam logic [PW:0] DEPTH_W = (PW + 1)'(DEPTH);
    localparam logic [PW:0] HALF_STD = (PW + 1)'(DEPTH / 2);
    localparam logic [PW:0] HALF_FIRST_WORD_FALL_THROUGH = (PW + 1)'(DEPTH / 2 + 1);

    typedef struct packed {
        fsf_pins_s pinMeta;
        fsf_pins_s pinSync;
        fsf_cfg_s cfg;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic outValid;
        logic [FSF_DATA_W-1:0] dataOut;
        logic [PW-1:0] emptyOffset;
        logic wrEvent;
        logic rdEvent;
        logic emptyN;
        logic fullN;
        logic almostEmptyN;
        logic halfFullN;
        logic [31:0] busData;
    } fsf_state_s;

    fsf_state_s state_reg;
    fsf_state_s state_next;
    logic [FSF_DATA_W-1:0] mem [DEPTH];
    logic wrTake;

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [FSF_DATA_W-1:0] widthMask(
        input logic [1:0] w,
        input logic [FSF_DATA_W-1:0] d
    );
        logic [FSF_DATA_W-1:0] r;
        r = d;
        if (w == FSF_W18)
        begin
            r = {18'h0, d[17:0]};
        end
        else if (w == FSF_W9)
        begin
            r = {27'h0, d[8:0]};
        end
        return r;
    endfunction : widthMask

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        logic master_reset_n;
        logic partial_reset_n;
        logic [PW-1:0] count;
        logic [PW:0] total;
        logic [PW:0] halfLimit;
        logic [PW:0] aeLimit;
        logic memEmpty;
        logic aeCond;
        logic rdTake;
        logic [PW-1:0] cntNext;
        master_reset_n = 1'b0;
        partial_reset_n = 1'b0;
        count = '0;
        total = '0;
        halfLimit = '0;
        aeLimit = '0;
        memEmpty = 1'b0;
        aeCond = 1'b0;
        rdTake = 1'b0;
        cntNext = '0;
        state_next = state_reg;
        state_next.pinMeta = pins;
        state_next.pinSync = state_reg.pinMeta;
        master_reset_n = !state_reg.pinSync.masterResetN;
        partial_reset_n = !state_reg.pinSync.partialResetN;

        count = state_reg.wrPtr - state_reg.rdPtr;
        total = {1'b0, count} + (PW + 1)'(state_reg.cfg.first_word_fall_through & state_reg.outValid);
        memEmpty = (count == '0);
        wrTake = writeEn && state_reg.fullN && ({1'b0, count} != DEPTH_W) && !master_reset_n && !partial_reset_n;
        state_next.wrEvent = wrTake;
        state_next.rdEvent = 1'b0;

        if (wrTake)
        begin
            state_next.wrPtr = state_reg.wrPtr + 1'b1;
        end

        if (retransmitReq)
        begin
            if (state_reg.cfg.normalRetx)
            begin
                state_next.rdPtr = '0;
                state_next.outValid = 1'b0;
                state_next.rdEvent = 1'b1;
            end
            else
            begin
                state_next.rdPtr = PW'(1);
                state_next.dataOut = mem[0];
                state_next.outValid = 1'b1;
                state_next.rdEvent = 1'b1;
            end
        end
        else if (state_reg.cfg.first_word_fall_through)
        begin
            rdTake = !memEmpty && (!state_reg.outValid || readEn);
            if (rdTake)
            begin
                state_next.dataOut = mem[state_reg.rdPtr[AW-1:0]];
                state_next.rdPtr = state_reg.rdPtr + 1'b1;
                state_next.outValid = 1'b1;
            end
            else if (readEn && state_reg.outValid)
            begin
                state_next.outValid = 1'b0;
            end
            state_next.rdEvent = readEn && state_reg.outValid;
        end
        else
        begin
            rdTake = readEn && state_reg.emptyN && !memEmpty;
            if (rdTake)
            begin
                state_next.dataOut = mem[state_reg.rdPtr[AW-1:0]];
                state_next.rdPtr = state_reg.rdPtr + 1'b1;
            end
            state_next.rdEvent = rdTake;
        end

        aeLimit = {1'b0, state_reg.emptyOffset};
        if (state_reg.cfg.first_word_fall_through)
        begin
            aeLimit = {1'b0, state_reg.emptyOffset} + 1'b1;
        end
        aeCond = (total <= aeLimit);
        if (state_reg.cfg.syncFlags)
        begin
            state_next.almostEmptyN = !aeCond;
        end
        else
        begin
            if (state_reg.rdEvent && aeCond)
            begin
                state_next.almostEmptyN = 1'b0;
            end
            else if (state_reg.wrEvent && !aeCond)
            begin
                state_next.almostEmptyN = 1'b1;
            end
        end

        halfLimit = HALF_STD;
        if (state_reg.cfg.first_word_fall_through)
        begin
            halfLimit = HALF_FIRST_WORD_FALL_THROUGH;
        end
        if (state_reg.wrEvent && total > halfLimit)
        begin
            state_next.halfFullN = 1'b0;
        end
        else if (state_reg.rdEvent && total <= halfLimit)
        begin
            state_next.halfFullN = 1'b1;
        end

        // full set at once so no write slips in, released a cycle late
        cntNext = state_next.wrPtr - state_next.rdPtr;
        if (state_reg.cfg.first_word_fall_through)
        begin
            state_next.fullN = (total != DEPTH_W + 1'b1)
                && (({1'b0, cntNext} + (PW + 1)'(state_next.outValid)) != DEPTH_W + 1'b1);
        end
        else
        begin
            state_next.fullN = ({1'b0, count} != DEPTH_W) && ({1'b0, cntNext} != DEPTH_W);
        end

        // empty set at once, released a cycle after the write
        if (state_reg.cfg.first_word_fall_through)
        begin
            state_next.emptyN = state_next.outValid;
        end
        else if (retransmitReq)
        begin
            state_next.emptyN = !state_reg.cfg.normalRetx;
        end
        else
        begin
            state_next.emptyN = !memEmpty && (cntNext != '0);
        end

        // unused upper lines forced to zero
        state_next.dataOut = widthMask(state_reg.cfg.width, state_next.dataOut);

        // register port
        if (regWrStrobe && regAddr == FSF_REG_OFFSET)
        begin
            state_next.emptyOffset = regWrData[PW-1:0];
        end
        state_next.busData = '0;
        if (regRdStrobe)
        begin
            case (regAddr)
                FSF_REG_OFFSET: state_next.busData = 32'(state_reg.emptyOffset);
                FSF_REG_STATUS:
                begin
                    state_next.busData[FSF_ST_EMPTY] = state_reg.emptyN;
                    state_next.busData[FSF_ST_FULL] = state_reg.fullN;
                    state_next.busData[FSF_ST_AEMPTY] = state_reg.almostEmptyN;
                    state_next.busData[FSF_ST_HFULL] = state_reg.halfFullN;
                    state_next.busData[FSF_ST_FIRST_WORD_FALL_THROUGH] = state_reg.cfg.first_word_fall_through;
                    state_next.busData[FSF_ST_SYNCF] = state_reg.cfg.syncFlags;
                    state_next.busData[FSF_ST_NORMRT] = state_reg.cfg.normalRetx;
                    state_next.busData[FSF_ST_WIDTH +: 2] = state_reg.cfg.width;
                end
                FSF_REG_COUNT: state_next.busData = 32'(total);
                default: state_next.busData = '0;
            endcase
        end

        // master and partial reset clear the pointers
        if (master_reset_n || partial_reset_n)
        begin
            state_next.wrPtr = '0;
            state_next.rdPtr = '0;
            state_next.outValid = 1'b0;
            state_next.dataOut = '0;
            state_next.wrEvent = 1'b0;
            state_next.rdEvent = 1'b0;
            state_next.emptyN = 1'b0;
            state_next.fullN = 1'b1;
            state_next.almostEmptyN = 1'b0;
            state_next.halfFullN = 1'b1;
        end
        if (master_reset_n)
        begin
            state_next.cfg.normalRetx = state_reg.pinSync.retransmitModeSelect;
            state_next.cfg.syncFlags = state_reg.pinSync.flagTimingSelect;
            state_next.cfg.first_word_fall_through = state_reg.pinSync.firstWordFallThrough;
            state_next.cfg.width = state_reg.pinSync.outputWidthSelect;
            state_next.emptyOffset = FSF_EMPTY_OFFSET_RST[PW-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= '0;
            state_reg.fullN <= 1'b1;
            state_reg.halfFullN <= 1'b1;
            state_reg.emptyOffset <= FSF_EMPTY_OFFSET_RST[PW-1:0];
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // storage has no reset; pointers alone define its contents
    always_ff @(posedge clk)
    begin
        if (wrTake)
        begin
            mem[state_reg.wrPtr[AW-1:0]] <= widthMask(state_reg.cfg.width, writeData);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign readDataOut = state_reg.dataOut;
    assign emptyFlagN = state_reg.emptyN;
    assign fullFlagN = state_reg.fullN;
    assign inputReadyN = !state_reg.fullN;
    assign almostEmptyFlagN = state_reg.almostEmptyN;
    assign halfFullFlagN = state_reg.halfFullN;
    assign regRdData = state_reg.busData;

endmodule : fsf_fifo_flags

// >>> dv/fsf_fifo_flags_chk.sv
/*
 fsf_fifo_flags_chk: port assertions for the flag and retransmit logic.
 assumes mode pins stay steady around master reset.
*/
`timescale 1ns/1ps
module fsf_fifo_flags_chk
    import fsf_pkg::*;
#(
    parameter int DEPTH = FSF_DEPTH_DEF
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // block inputs
    input wire fsf_pins_s pins,
    input wire logic writeEn,
    input wire logic readEn,
    input wire logic retransmitReq,
    // block outputs
    input wire logic [FSF_DATA_W-1:0] readDataOut,
    input wire logic emptyFlagN,
    input wire logic fullFlagN,
    input wire logic almostEmptyFlagN,
    input wire logic halfFullFlagN
);
    fsf_cfg_s cfg_reg;
    logic hold;
    // settings shadow the pins while master reset is low
    always_ff @(posedge clk)
    begin
        if (!pins.masterResetN)
            cfg_reg <= {pins.outputWidthSelect, pins.firstWordFallThrough,
                pins.flagTimingSelect, pins.retransmitModeSelect};
    end
    // pin resets reach the block two flops late, so the whole pin window is masked
    assign hold = rst || !pins.masterResetN || !pins.partialResetN;
    default clocking @(posedge clk); endclocking
    default disable iff (hold);
////////////////////////////////////////
    sequence s_retxSetup;
        !emptyFlagN ##1 emptyFlagN;
    endsequence
    property p_emptyRelease;
        !cfg_reg.first_word_fall_through && !emptyFlagN && writeEn && !retransmitReq ##1 !retransmitReq
            |=> emptyFlagN;
    endproperty
    a_emptyRelease: assert property (p_emptyRelease) else $error("empty not released");
    property p_fullRelease;
        !cfg_reg.first_word_fall_through && !fullFlagN && readEn && !writeEn |-> ##2 fullFlagN;
    endproperty
    a_fullRelease: assert property (p_fullRelease) else $error("full not released");
    property p_hfSet;
        $fell(halfFullFlagN) |-> $past(writeEn) || $past(writeEn, 2) || $past(retransmitReq);
    endproperty
    a_hfSet: assert property (p_hfSet) else $error("half-full set without write");
    property p_hfClear;
        $rose(halfFullFlagN) |-> $past(readEn) || $past(readEn, 2);
    endproperty
    a_hfClear: assert property (p_hfClear) else $error("half-full cleared without read");
    property p_aeFall;
        !cfg_reg.syncFlags && $fell(almostEmptyFlagN) |-> $past(readEn) || $past(readEn, 2);
    endproperty
    a_aeFall: assert property (p_aeFall) else $error("almost-empty set without read");
    property p_aeRise;
        !cfg_reg.syncFlags && $rose(almostEmptyFlagN) |-> $past(writeEn) || $past(writeEn, 2)
            || $past(retransmitReq);
    endproperty
    a_aeRise: assert property (p_aeRise) else $error("almost-empty cleared without write");
    property p_normRetx;
        cfg_reg.normalRetx && !cfg_reg.first_word_fall_through && retransmitReq |=> s_retxSetup;
    endproperty
    a_normRetx: assert property (p_normRetx) else $error("retransmit setup wrong");
    property p_zeroRetx;
        !cfg_reg.normalRetx && !cfg_reg.first_word_fall_through && retransmitReq && !emptyFlagN |=> emptyFlagN;
    endproperty
    a_zeroRetx: assert property (p_zeroRetx) else $error("zero latency empty late");
    property p_width;
        (cfg_reg.width != FSF_W9 || readDataOut[35:9] == '0)
            && (cfg_reg.width != FSF_W18 || readDataOut[35:18] == '0);
    endproperty
    a_width: assert property (p_width) else $error("unused data lines active");
endmodule : fsf_fifo_flags_chk

bind fsf_fifo_flags fsf_fifo_flags_chk #(.DEPTH(DEPTH)) chk_u (.clk(clk), .rst(rst),
    .pins(pins), .writeEn(writeEn), .readEn(readEn), .retransmitReq(retransmitReq),
    .readDataOut(readDataOut), .emptyFlagN(emptyFlagN), .fullFlagN(fullFlagN),
    .almostEmptyFlagN(almostEmptyFlagN), .halfFullFlagN(halfFullFlagN));

// >>> dv/fsf_producer.sv
/*
 fsf_producer: write-side producer, bursts of random words.
 assumes the block's full flag gates every write.
*/
`timescale 1ns/1ps
module fsf_producer
    import fsf_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // burst request
    input wire logic start,
    input wire logic [4:0] num,
    output logic busy,
    // write port
    input wire logic fullFlagN,
    output logic writeEn,
    output logic [FSF_DATA_W-1:0] writeData
);
    logic [4:0] left_reg = 5'h0;
    integer seed = 32'ha52e;
    assign busy = left_reg != 5'h0;
    // a real producer stalls on full instead of losing words
    assign writeEn = busy && fullFlagN;
    always @(posedge clk)
    begin
        if (rst)
            left_reg <= 5'h0;
        else if (start)
            left_reg <= num;
        else if (writeEn)
            left_reg <= left_reg - 5'h1;
        if (rst || writeEn)
            writeData <= FSF_DATA_W'({$random(seed), $random(seed)});
    end
endmodule : fsf_producer

// >>> dv/test_fsf_fifo_flags.sv
/*
 test_fsf_fifo_flags: self-checking bench for the fifo flag block.
 assumes the producer model drives writes; depth shortened to 16.
*/
`timescale 1ns/1ps
module test_fsf_fifo_flags
    import fsf_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, start = 1'b0, readEn = 1'b0, retransmitReq = 1'b0;
    logic busy, writeEn, emptyFlagN, fullFlagN, inputReadyN, almostEmptyFlagN, halfFullFlagN;
    logic regWrStrobe = 1'b0, regRdStrobe = 1'b0, pend = 1'b0, zeroRetx = 1'b0;
    fsf_pins_s pins = '0;
    logic [4:0] num = 5'h0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWrData = 32'h0, regRdData;
    logic [FSF_DATA_W-1:0] writeData, readDataOut, mask = 36'hf_ffff_ffff;
    logic [FSF_DATA_W-1:0] hist[$], expQ[$];
    int fails = 0, checkCount = 0, rdIdx = 0;
    initial forever #5 clk = ~clk;
    fsf_fifo_flags #(.DEPTH(16)) dut_u (.clk(clk), .rst(rst), .pins(pins), .writeEn(writeEn),
        .writeData(writeData), .readEn(readEn), .retransmitReq(retransmitReq),
        .readDataOut(readDataOut), .emptyFlagN(emptyFlagN), .fullFlagN(fullFlagN),
        .inputReadyN(inputReadyN), .almostEmptyFlagN(almostEmptyFlagN),
        .halfFullFlagN(halfFullFlagN), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData));
    fsf_producer prod_u (.clk(clk), .rst(rst), .start(start), .num(num), .busy(busy),
        .fullFlagN(fullFlagN), .writeEn(writeEn), .writeData(writeData));
////////////////////////////////////////
    task automatic printVerdict;
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : printVerdict
    task automatic chk(input logic [FSF_DATA_W-1:0] got, input logic [FSF_DATA_W-1:0] exp);
        checkCount++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cfg(input logic [1:0] w, input logic fw, input logic sy, input logic nr);
        @(posedge clk);
        pins <= '{w, fw, sy, nr, 1'b1, 1'b0};
        zeroRetx <= !nr;
        mask = (w == FSF_W9) ? 36'h1ff : (w == FSF_W18) ? 36'h3_ffff : 36'hf_ffff_ffff;
        repeat (6) @(posedge clk);
        pins.masterResetN <= 1'b1;
        repeat (4) @(posedge clk);
        hist.delete();
        rdIdx = 0;
        #1;
    endtask : cfg
    task automatic wr(input int n);
        @(posedge clk);
        num <= 5'(n);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int i = 0; i <= 50; i++)
        begin
            #1;
            if (busy === 1'b0)
                break;
            if (i == 50)
            begin
                fails++;
                printVerdict();
            end
            @(posedge clk);
        end
        repeat (3) @(posedge clk);
        #1;
    endtask : wr
    task automatic rd(input int n);
        repeat (n)
        begin
            @(posedge clk);
            readEn <= 1'b1;
            expQ.push_back(hist[rdIdx]);
            rdIdx++;
            @(posedge clk);
            readEn <= 1'b0;
        end
        repeat (3) @(posedge clk);
        #1;
    endtask : rd
    task automatic retx;
        @(posedge clk);
        retransmitReq <= 1'b1;
        rdIdx = zeroRetx;
        if (zeroRetx)
            expQ.push_back(hist[0]);
        @(posedge clk);
        retransmitReq <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        // reads only once empty is released
        chk(emptyFlagN, 1'b1);
    endtask : retx
    task automatic regAcc(input logic wrt, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= wrt;
        regRdStrobe <= !wrt;
        @(posedge clk);
        regWrStrobe <= 1'b0;
        regRdStrobe <= 1'b0;
        #1;
        if (!wrt)
            chk(36'(regRdData), 36'(d));
    endtask : regAcc
////////////////////////////////////////
    // the monitor knows a result is due one cycle after a taken read
    always @(negedge clk)
    begin
        if (pend)
            chk(readDataOut, expQ.pop_front());
        pend = (readEn && emptyFlagN) || (retransmitReq && zeroRetx);
        if (writeEn && fullFlagN)
            hist.push_back(writeData & mask);
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        cfg(FSF_W36, 1'b0, 1'b0, 1'b1);
        chk(emptyFlagN, 1'b0);
        wr(7);
        chk(almostEmptyFlagN, 1'b0);
        wr(1);
        chk(almostEmptyFlagN, 1'b1);
        chk(halfFullFlagN, 1'b1);
        wr(1);
        chk(halfFullFlagN, 1'b0);
        rd(1);
        chk(halfFullFlagN, 1'b1);
        rd(1);
        chk(almostEmptyFlagN, 1'b0);
        wr(9);
        chk(fullFlagN, 1'b0);
        chk(inputReadyN, 1'b1);
        rd(1);
        chk(fullFlagN, 1'b1);
        rd(15);
        chk(emptyFlagN, 1'b0);
        regAcc(1'b1, FSF_REG_OFFSET, 32'h3);
        regAcc(1'b0, FSF_REG_OFFSET, 32'h3);
        regAcc(1'b0, FSF_REG_STATUS, 32'h4a);
        regAcc(1'b0, 4'hc, 32'h0);
        wr(3);
        chk(almostEmptyFlagN, 1'b0);
        regAcc(1'b0, FSF_REG_COUNT, 32'h3);
        wr(1);
        chk(almostEmptyFlagN, 1'b1);
        rd(4);
        for (int w = 1; w <= 2; w++)
        begin
            cfg(2'(w), 1'b0, 1'b1, 1'b0);
            wr(2);
            rd(2);
            chk(almostEmptyFlagN, 1'b0);
            retx();
            rd(1);
        end
        cfg(FSF_W36, 1'b0, 1'b0, 1'b1);
        wr(3);
        rd(1);
        retx();
        rd(3);
        cfg(FSF_W36, 1'b1, 1'b1, 1'b1);
        wr(8);
        chk(almostEmptyFlagN, 1'b0);
        chk(emptyFlagN, 1'b1);
        chk(readDataOut, hist[0]);
        wr(1);
        chk(almostEmptyFlagN, 1'b1);
        chk(halfFullFlagN, 1'b1);
        wr(1);
        chk(halfFullFlagN, 1'b0);
        @(posedge clk);
        pins.partialResetN <= 1'b0;
        repeat (6) @(posedge clk);
        pins.partialResetN <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(halfFullFlagN, 1'b1);
        chk(36'(expQ.size()), 36'h0);
        printVerdict();
    end
endmodule : test_fsf_fifo_flags
